/* hw/flom_logic_op.sv */
// fragment logic-op stage with per-sample write masks, all samples in one cycle, and resolve
`timescale 1ns/1ps
`include "flom_regs.svh"
module flom_logic_op #(
  parameter int NB = 2,
  parameter int NS = 4,
  parameter int CW = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic cfg_write,
  input wire flom_pkg::flom_func_t cfg_function,
  input wire logic cfg_index_enable,
  input wire logic cfg_color_enable,
  output logic [3:0] select_bitwise_function,
  output logic index_logic_enable,
  output logic color_logic_enable,
  input wire logic srgb_conversion_enable,
  input wire logic blend_enable,
  input wire logic index_mode,
  input wire logic multisample_enable,
  input wire logic sample_buffer_present,
  input wire logic center_sample_shortcut,
  input wire logic draw_none,
  input wire logic [NB-1:0] draw_select,
  input wire logic [NB-1:0] dst_is_float,
  input wire logic [NB-1:0] dst_is_srgb,
  input wire logic frag_valid,
  input wire logic [NB*4*CW-1:0] frag_color,
  input wire logic [NB*4*CW-1:0] blend_color,
  input wire logic [NS-1:0] coverage,
  input wire logic [NS-1:0] test_pass,
  input wire logic center_depth_pass,
  input wire logic [NB*NS*4*CW-1:0] dst_sample,
  output logic out_valid,
  output logic blend_bypass,
  output logic [NB*NS*4*CW-1:0] sample_color,
  output logic [NB*NS-1:0] sample_color_we,
  output logic [NS-1:0] stencil_we,
  output logic [NS-1:0] depth_we,
  output logic [NB*4*CW-1:0] resolve_color,
  output logic [NB-1:0] resolve_we
);
  import flom_pkg::*;

  localparam int NC = `FLOM_NUM_COMPONENTS;
  localparam int SB = (NS > 1) ? $clog2(NS) : 1;

  typedef struct packed {
    flom_func_t func;
    logic idx_en;
    logic col_en;
    logic valid;
    logic bypass;
    logic [NB*NS*NC*CW-1:0] scol;
    logic [NB*NS-1:0] scol_we;
    logic [NS-1:0] st_we;
    logic [NS-1:0] dp_we;
    logic [NB*NC*CW-1:0] rcol;
    logic [NB-1:0] rwe;
  } flom_state_s;

  flom_state_s state_reg;
  flom_state_s state_next;

  // bitwise function; codes match X11 numbering so software passes them through
  function automatic logic [CW-1:0] flom_bitop(flom_func_t f, logic [CW-1:0] s,
                                               logic [CW-1:0] d);
    logic [CW-1:0] r;
    r = '0;
    unique case (f)
      `FLOM_FN_CLEAR: r = '0;
      `FLOM_FN_AND: r = s & d;
      `FLOM_FN_AND_REVERSE: r = s & ~d;
      `FLOM_FN_COPY: r = s;
      `FLOM_FN_NOT_SRC_AND_DST: r = ~s & d;
      `FLOM_FN_KEEP_DESTINATION: r = d;
      `FLOM_FN_XOR: r = s ^ d;
      `FLOM_FN_OR: r = s | d;
      `FLOM_FN_NOR: r = ~(s | d);
      `FLOM_FN_EQUIVALENCE: r = ~(s ^ d);
      `FLOM_FN_INVERT: r = ~d;
      `FLOM_FN_OR_REVERSE: r = s | ~d;
      `FLOM_FN_INVERTED_SOURCE: r = ~s;
      `FLOM_FN_NOT_SRC_OR_DST: r = ~s | d;
      `FLOM_FN_NAND: r = ~(s & d);
      `FLOM_FN_SET: r = '1;
    endcase
    return r;
  endfunction : flom_bitop

  logic per_sample;
  logic full_cover;
  logic shortcut;
  logic go;
  logic [NS-1:0] col_wr;
  logic [NS-1:0] st_wr;
  logic [NS-1:0] dp_wr;
  logic [NB-1:0] logic_on;
  logic [NB-1:0] buf_wr;
  logic [NB*NS*NC*CW-1:0] new_w;
  logic [NB*NC*CW-1:0] avg_w;

  assign per_sample = multisample_enable & sample_buffer_present;
  assign full_cover = ~multisample_enable & sample_buffer_present;
  assign shortcut = full_cover & center_sample_shortcut;
  // draw none suppresses every write, sample store included
  assign go = frag_valid & ~draw_none;

  // sample write masks; tests are evaluated upstream, only their results arrive here
  always_comb begin
    col_wr = '0;
    st_wr = '0;
    dp_wr = '0;
    if (per_sample) begin
      col_wr = coverage & test_pass;
      st_wr = coverage;
      dp_wr = coverage & test_pass;
    end else if (shortcut) begin
      st_wr = '1;
      col_wr = {NS{center_depth_pass}};
      dp_wr = {NS{center_depth_pass}};
    end else if (full_cover) begin
      col_wr = test_pass;
      st_wr = '1;
      dp_wr = test_pass;
    end else begin
      col_wr[0] = test_pass[0];
      st_wr[0] = 1'b1;
      dp_wr[0] = test_pass[0];
    end
  end

  genvar b, s, c;
  generate
    for (b = 0; b < NB; b++) begin : g_buf
      // float targets, and sRGB targets while sRGB conversion is enabled, keep the plain source value
      assign logic_on[b] = (index_mode ? state_reg.idx_en : state_reg.col_en)
                           & ~dst_is_float[b]
                           & ~(srgb_conversion_enable & dst_is_srgb[b]);
      // aliased selections are not checked; such an image ends undefined
      assign buf_wr[b] = go & draw_select[b];
      for (c = 0; c < NC; c++) begin : g_comp
        logic [CW-1:0] src;
        logic [CW+SB-1:0] acc;
        // blended value only used while colour logic is off
        assign src = (blend_enable & ~state_reg.col_en & ~index_mode)
                     ? blend_color[(b*NC+c)*CW +: CW]
                     : frag_color[(b*NC+c)*CW +: CW];
        for (s = 0; s < NS; s++) begin : g_smp
          logic [CW-1:0] dst;
          logic [CW-1:0] res;
          assign dst = dst_sample[((b*NS+s)*NC+c)*CW +: CW];
          assign res = logic_on[b] ? flom_bitop(state_reg.func, src, dst) : src;
          // samples not written keep their stored value for the resolve
          assign new_w[((b*NS+s)*NC+c)*CW +: CW] = (buf_wr[b] & col_wr[s]) ? res : dst;
        end
        always_comb begin
          acc = '0;
          for (int k = 0; k < NS; k++) begin
            acc = acc + (CW+SB)'(new_w[((b*NS+k)*NC+c)*CW +: CW]);
          end
        end
        // power-of-two sample count assumed so the average is a shift
        assign avg_w[(b*NC+c)*CW +: CW] = (NS > 1) ? acc[SB +: CW] : acc[CW-1:0];
      end
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    if (cfg_write) begin
      state_next.func = cfg_function;
      state_next.idx_en = cfg_index_enable;
      state_next.col_en = cfg_color_enable;
    end
    state_next.valid = frag_valid;
    state_next.bypass = state_reg.col_en;
    state_next.scol = new_w;
    state_next.st_we = go ? st_wr : '0;
    state_next.dp_we = go ? dp_wr : '0;
    for (int i = 0; i < NB; i++) begin
      state_next.scol_we[i*NS +: NS] = buf_wr[i] ? col_wr : '0;
      // colour buffers only see the combined value, never a raw sample
      state_next.rwe[i] = buf_wr[i] & sample_buffer_present & (|col_wr);
    end
    state_next.rcol = avg_w;
    if (srst) begin
      state_next = '0;
      state_next.func = `FLOM_RST_FUNCTION;
      state_next.idx_en = `FLOM_RST_INDEX_EN;
      state_next.col_en = `FLOM_RST_COLOR_EN;
    end
  end

  // write-through each fragment, so no deferred resolve state to keep coherent
  always_ff @(posedge clk) begin
    if (srst | ce) begin
      state_reg <= state_next;
    end
  end

  assign select_bitwise_function = state_reg.func;
  assign index_logic_enable = state_reg.idx_en;
  assign color_logic_enable = state_reg.col_en;
  assign out_valid = state_reg.valid;
  assign blend_bypass = state_reg.bypass;
  assign sample_color = state_reg.scol;
  assign sample_color_we = state_reg.scol_we;
  assign stencil_we = state_reg.st_we;
  assign depth_we = state_reg.dp_we;
  assign resolve_color = state_reg.rcol;
  assign resolve_we = state_reg.rwe;
endmodule : flom_logic_op

/* hw/flom_regs.svh */
// constants for the fragment logic-op and multisample stage
`ifndef FLOM_REGS_SVH
`define FLOM_REGS_SVH
`define FLOM_FN_CLEAR 4'h0
`define FLOM_FN_AND 4'h1
`define FLOM_FN_AND_REVERSE 4'h2
`define FLOM_FN_COPY 4'h3
`define FLOM_FN_NOT_SRC_AND_DST 4'h4
`define FLOM_FN_KEEP_DESTINATION 4'h5
`define FLOM_FN_XOR 4'h6
`define FLOM_FN_OR 4'h7
`define FLOM_FN_NOR 4'h8
`define FLOM_FN_EQUIVALENCE 4'h9
`define FLOM_FN_INVERT 4'hA
`define FLOM_FN_OR_REVERSE 4'hB
`define FLOM_FN_INVERTED_SOURCE 4'hC
`define FLOM_FN_NOT_SRC_OR_DST 4'hD
`define FLOM_FN_NAND 4'hE
`define FLOM_FN_SET 4'hF
`define FLOM_RST_FUNCTION `FLOM_FN_COPY
`define FLOM_RST_INDEX_EN 1'b0
`define FLOM_RST_COLOR_EN 1'b0
`define FLOM_NUM_COMPONENTS 4
`endif

/* hw/flom_pkg.sv */
// types for the fragment logic-op and multisample stage
package flom_pkg;
  typedef logic [3:0] flom_func_t;
endpackage : flom_pkg

/* dv/flom_sva.sv */
// port checker for the fragment logic-op stage
`timescale 1ns/1ps
module flom_sva #(parameter int NB = 2, parameter int NS = 4) (
  input wire logic clk, srst, ce, draw_none, frag_valid, out_valid,
  input wire logic multisample_enable, sample_buffer_present, center_sample_shortcut,
  input wire logic center_depth_pass, color_logic_enable, index_logic_enable, blend_bypass,
  input wire logic [3:0] select_bitwise_function,
  input wire logic [NB-1:0] draw_select, resolve_we,
  input wire logic [NS-1:0] coverage, test_pass, stencil_we, depth_we,
  input wire logic [NB*NS-1:0] sample_color_we
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_go;
    ce && frag_valid && !draw_none && sample_buffer_present;
  endsequence
  rst_state_a:
    assert property ($fell(srst) |-> select_bitwise_function == 4'h3 && !color_logic_enable
      && !index_logic_enable) else $error("reset state wrong");
  blend_off_a:
    assert property (ce |=> blend_bypass == $past(color_logic_enable))
      else $error("blend bypass wrong");
  no_write_a:
    assert property (ce && (draw_none || !frag_valid) |=>
      !{sample_color_we, stencil_we, depth_we, resolve_we}) else $error("write while idle");
  frag_out_a:
    assert property (ce && frag_valid |=> out_valid) else $error("no output pulse");
  per_sample_a:
    assert property (s_go ##0 multisample_enable |=> stencil_we == $past(coverage)
      && depth_we == $past(coverage & test_pass)) else $error("per-sample masks wrong");
  shortcut_a:
    assert property (s_go ##0 (!multisample_enable && center_sample_shortcut) |=>
      &stencil_we && depth_we == {NS{$past(center_depth_pass)}}) else $error("shortcut wrong");
  full_cov_a:
    assert property (s_go ##0 !(multisample_enable || center_sample_shortcut) |=>
      &stencil_we && depth_we == $past(test_pass)) else $error("full coverage wrong");
  resolve_sel_a:
    assert property (ce |=> (resolve_we & ~$past(draw_select)) == 0)
      else $error("resolve to unselected buffer");
endmodule : flom_sva

/* dv/flom_store.sv */
// far-side sample store model, preloadable by the bench
`timescale 1ns/1ps
module flom_store #(parameter int W = 64, parameter int N = 4) (
  input wire logic clk, ld,
  input wire logic [W-1:0] ld_val, wr,
  input wire logic [N-1:0] we,
  output logic [W-1:0] rd
);
  always_ff @(posedge clk) begin
    if (ld) begin
      rd <= ld_val;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (we[i]) rd[i*(W/N) +: W/N] <= wr[i*(W/N) +: W/N];
      end
    end
  end
endmodule : flom_store

/* dv/tb_flom_logic_op.sv */
// bench for the fragment logic-op stage
`timescale 1ns/1ps
module tb_flom_logic_op;
  localparam int NB = 2;
  localparam int NS = 2;
  localparam int CW = 4;
  logic clk = 0, srst = 1, cw = 0, ie = 0, cen = 0, sre = 0, ms = 1, pr = 1, sc = 0;
  logic dn = 0, fv = 0, cdp = 0, ld = 0, bp, ov, iq, cq;
  logic en = 1, im = 0;
  logic [3:0] fn = 4'h3, sel, we;
  logic [1:0] ds = 2'h3, fl = 2'h0, sr = 2'h0, cov = 2'h3, tp = 2'h3, swe, dwe, rwe;
  logic [31:0] src = 32'h5A3C_96E1, bc = 32'h0F0F_0F0F, rco;
  logic [63:0] dv = 64'hC3A5_0FF0_33CC_F00F, dst, sco;
  int mismatches = 0;
  int n_compared = 0;
  flom_logic_op #(.NB(NB), .NS(NS), .CW(CW)) i_flom_logic_op (.clk(clk), .srst(srst),
    .ce(en), .cfg_write(cw), .cfg_function(fn), .cfg_index_enable(ie),
    .cfg_color_enable(cen), .select_bitwise_function(sel), .index_logic_enable(iq),
    .color_logic_enable(cq), .srgb_conversion_enable(sre), .blend_enable(1'b1),
    .index_mode(im), .multisample_enable(ms), .sample_buffer_present(pr),
    .center_sample_shortcut(sc), .draw_none(dn), .draw_select(ds), .dst_is_float(fl),
    .dst_is_srgb(sr), .frag_valid(fv), .frag_color(src), .blend_color(bc), .coverage(cov),
    .test_pass(tp), .center_depth_pass(cdp), .dst_sample(dst), .out_valid(ov),
    .blend_bypass(bp), .sample_color(sco), .sample_color_we(we), .stencil_we(swe),
    .depth_we(dwe), .resolve_color(rco), .resolve_we(rwe));
  flom_store #(.W(64), .N(4)) i_flom_store (.clk(clk), .ld(ld), .ld_val(dv), .wr(sco),
    .we(we), .rd(dst));
  initial forever #50 clk = ~clk;
  task chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("Error t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  // code bits are the truth table, indexed by inverted source and stored bit
  function automatic logic [63:0] ex(input logic [3:0] f, input logic [31:0] s,
                                     input logic [63:0] d);
    for (int i = 0; i < 64; i++) ex[i] = f[{~s[i/32*16+i%16], ~d[i]}];
  endfunction : ex
  task cfg(input logic [3:0] f, input logic i, input logic c);
    @(negedge clk);
    {cw, fn, ie, cen} = {1'b1, f, i, c};
    @(negedge clk);
    cw = 0;
    chk({sel, iq, cq}, {f, i, c});
  endtask : cfg
  // preload the store, then present one fragment; returns with outputs settled
  task frag;
    @(negedge clk);
    ld = 1;
    @(negedge clk);
    {ld, fv} = 2'b01;
    @(negedge clk);
    fv = 0;
  endtask : frag
  task t_funcs;
    for (int f = 0; f < 16; f++) begin
      cfg(f[3:0], 1'b0, 1'b1);
      frag;
      chk(sco, ex(f[3:0], src, dv));
      chk({ov, bp, we, rwe}, {1'b1, 1'b1, 4'hF, 2'h3});
      if (f == 3) chk(rco, src);
    end
    $display("function test done");
  endtask : t_funcs
  task t_skip;
    logic [63:0] e;
    cfg(4'hA, 1'b1, 1'b1);
    {fl, sre, sr} = 5'b10101;
    frag;
    chk(bp, 1'b1);
    chk(sco, ex(4'h3, src, dv));
    sre = 0;
    frag;
    e = ex(4'h3, src, dv) & 64'hFFFF_FFFF_0000_0000;
    e = e | (ex(4'hA, src, dv) & 64'h0000_0000_FFFF_FFFF);
    chk(sco, e);
    {fl, sr} = 4'h0;
    cfg(4'hA, 1'b1, 1'b0);
    im = 1;
    frag;
    chk(sco, ex(4'hA, src, dv));
    chk(bp, 1'b0);
    im = 0;
    cfg(4'hA, 1'b0, 1'b0);
    frag;
    chk(sco, {bc[31:16], bc[31:16], bc[15:0], bc[15:0]});
    $display("skip test done");
  endtask : t_skip
  task t_cov;
    logic [63:0] e;
    cfg(4'hC, 1'b0, 1'b1);
    cov = 2'b01;
    frag;
    e = ex(4'hC, src, dv);
    e = (e & 64'h0000_FFFF_0000_FFFF) | (dv & 64'hFFFF_0000_FFFF_0000);
    chk(we, 4'h5);
    chk(sco, e);
    {cov, tp, ds} = 6'b111001;
    frag;
    chk({we, rwe}, {4'h2, 2'h1});
    // clock enable low: last answer must stand
    en = 0;
    frag;
    chk({ov, we, rwe}, {1'b1, 4'h2, 2'h1});
    en = 1;
    {tp, ds} = 4'hF;
    $display("coverage test done");
  endtask : t_cov
  task t_short;
    {ms, sc, cdp} = 3'b010;
    frag;
    chk({swe, dwe, we}, {4'hC, 4'h0});
    cdp = 1;
    frag;
    chk({swe, dwe, we}, {4'hF, 4'hF});
    {sc, tp} = 3'b001;
    frag;
    chk({swe, dwe, we}, {4'hD, 4'h5});
    dn = 1;
    frag;
    chk({swe, dwe, we, rwe}, 10'h0);
    $display("shortcut test done");
  endtask : t_short
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(negedge clk);
    srst = 0;
    chk({sel, iq, cq, bp}, {4'h3, 3'h0});
    t_funcs;
    t_skip;
    t_cov;
    t_short;
    complete_run;
  end
  // all tests need about 130 cycles
  initial begin
    #200000;
    mismatches++;
    complete_run;
  end
endmodule : tb_flom_logic_op
bind flom_logic_op flom_sva #(.NB(NB), .NS(NS)) i_flom_sva (.*);
